// file: cmc_params.svh
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
`define CMC_CLK_HZ 100000000
`define CMC_OFF_CTRL 32'h00
`define CMC_OFF_STATUS 32'h04
`define CMC_OFF_DOFS 32'h08
`define CMC_OFF_DSPAN 32'h0c
`define CMC_OFF_GZERO 32'h10
`define CMC_OFF_GGAIN 32'h14
`define CMC_OFF_RZERO 32'h18
`define CMC_OFF_RGAIN 32'h1c
`define CMC_OFF_GFORCE 32'h20
`define CMC_OFF_RFORCE 32'h24
`define CMC_OFF_DIAL 32'h28
`define CMC_CTRL_DUAL 0
`define CMC_CTRL_ZDONE 1
`define CMC_CTRL_LOAD 2
`define CMC_RST_DOFS 16'h0000
`define CMC_RST_DSPAN 16'h8000
`define CMC_RST_GAIN 16'h4000
`define CMC_RST_ZERO 16'h0000
`define CMC_HOLD_MS 3000
`define CMC_ZCAL_MS 15000
`define CMC_REFRESH_MS 25
`define CMC_BLINK_MS 250
`define CMC_LAMP_MS 500
`define CMC_SWEEP_MS 2000
`define CMC_DEB_MS 20
`define CMC_MS_CYC (`CMC_CLK_HZ / 1000)
`define CMC_FULL 16'hffff
`define CMC_SWEEP_TOP 16'h8000
`endif

// file: cmc_pkg.sv
package cmc_pkg;
    typedef enum logic [8:0] {
        CMC_LAMP = 9'h001,
        CMC_NORMAL = 9'h002,
        CMC_DZERO = 9'h004,
        CMC_DSPAN = 9'h008,
        CMC_GZERO = 9'h010,
        CMC_GGAIN = 9'h020,
        CMC_RZERO = 9'h040,
        CMC_RGAIN = 9'h080,
        CMC_ERROR = 9'h100
    } cmc_mode_t;
endpackage

// file: cmc_calibration_menu.sv
`timescale 1ns/10ps
`include "cmc_params.svh"
// Behaviour
// - At power-up both LEDs light briefly, then both go off.
// - Dual variant cycles seven modes in the listed order.
// - Single variant cycles five modes, skipping the red-input modes.
// - Normal both off, dial zero both on, dial span both blink.
// - Green zero: green steady, red off; green gain: green blinks.
// - Red zero: red steady, green off; red gain: red blinks.
// - Error blinks green and red alternately, never together.
// - Menu held over three seconds in normal enters dial zero.
// - In dial zero, minus and plus lower or raise the dial offset.
// - Short menu press during calibration advances to the next mode, except while auto zero runs.
// - In dial span mode, minus and plus adjust the dial span.
// - In input zero, one minus or plus press starts auto zero, lasting 15 s.
// - Finished auto zero moves by itself to that input's gain mode.
// - In input gain, minus and plus step that input's gain.
// - Menu in the last calibration mode restarts to normal, LEDs off.
// - After power-up the dial sweeps to the 80 daN mark and back.
// - Error clears on reset or one menu press; re-raised if fault stays.
// - Passing a mode without adjustment leaves its setting unchanged.
// - Unconnected load cell enters error and drives dial to full scale.
// - Dual variant drives the dial with the larger input force.
// - The dial output is refreshed once every 25 ms.
module cmc_calibration_menu #(
    parameter int HOLD_CYC = `CMC_HOLD_MS * `CMC_MS_CYC,
    parameter int ZCAL_CYC = `CMC_ZCAL_MS * `CMC_MS_CYC,
    parameter int REFRESH_CYC = `CMC_REFRESH_MS * `CMC_MS_CYC,
    parameter int BLINK_CYC = `CMC_BLINK_MS * `CMC_MS_CYC,
    parameter int LAMP_CYC = `CMC_LAMP_MS * `CMC_MS_CYC,
    parameter int SWEEP_CYC = `CMC_SWEEP_MS * `CMC_MS_CYC,
    parameter int DEB_CYC = `CMC_DEB_MS * `CMC_MS_CYC,
    parameter logic [15:0] STEP = 16'h0010
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Operator buttons, active low pins.
    input wire logic menuBtn_n,
    input wire logic minusBtn_n,
    input wire logic plusBtn_n,
    // Load cell detect pins, high when a cell is present.
    input wire logic greenCellPresent,
    input wire logic redCellPresent,
    // Indicator LEDs and dial value.
    output logic greenLed,
    output logic redLed,
    output logic [15:0] dialValue,
    // Request to save calibration to non-volatile storage.
    output logic saveReq
);
    import cmc_pkg::*;

    localparam int NB = 5;
    logic [NB-1:0] pinRaw;
    logic [NB-1:0] sync1_q;
    logic [NB-1:0] sync2_q;
    logic [NB-1:0] deb_q;
    logic [NB-1:0] debPrev_q;
    logic [NB-1:0] rise;
    cmc_mode_t mode_q;
    logic dual_q;
    logic [31:0] timer_q;
    logic [31:0] blinkCnt_q;
    logic blink_q;
    logic [31:0] refresh_q;
    logic zcalBusy_q;
    logic [31:0] zcalCnt_q;
    logic [15:0] dialOfs_q;
    logic [15:0] dialSpan_q;
    logic [15:0] greenZero_q;
    logic [15:0] greenGain_q;
    logic [15:0] redZero_q;
    logic [15:0] redGain_q;
    logic [15:0] greenForce_q;
    logic [15:0] redForce_q;
    logic [15:0] sweep_q;
    logic sweepUp_q;
    logic sweepOn_q;
    logic [16:0] gNet;
    logic [16:0] rNet;
    logic [15:0] peakForce;
    logic [31:0] scaled;
    logic cellFault;
    logic menuPress;
    logic menuHeld;
    logic minusPress;
    logic plusPress;
    logic apbAcc;
    logic apbWr;
    logic zcalDone;

    assign pinRaw = {redCellPresent, greenCellPresent, ~plusBtn_n,
        ~minusBtn_n, ~menuBtn_n};

    // Both stages of every pin synchroniser.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
        end
    end

    // Each input must hold a new level for DEB_CYC before it is taken.
    generate
        for (genvar i = 0; i < NB; i++)
        begin : g_deb
            logic [31:0] cnt_q;
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                begin
                    cnt_q <= '0;
                    deb_q[i] <= 1'b0;
                    debPrev_q[i] <= 1'b0;
                end
                else
                begin
                    debPrev_q[i] <= deb_q[i];
                    if (sync2_q[i] == deb_q[i])
                        cnt_q <= '0;
                    else if (cnt_q >= 32'(DEB_CYC - 1))
                    begin
                        cnt_q <= '0;
                        deb_q[i] <= sync2_q[i];
                    end
                    else
                        cnt_q <= cnt_q + 32'h1;
                end
            end
            assign rise[i] = deb_q[i] & ~debPrev_q[i];
        end
    endgenerate

    // Menu presses act on release so a long hold is not also a short press.
    assign menuPress = ~deb_q[0] & debPrev_q[0] &
        (timer_q < 32'(HOLD_CYC));
    assign menuHeld = deb_q[0] && timer_q >= 32'(HOLD_CYC);
    assign minusPress = rise[1];
    assign plusPress = rise[2];
    assign cellFault = ~deb_q[3] | (dual_q & ~deb_q[4]);
    assign apbAcc = psel & penable;
    assign apbWr = apbAcc & pwrite;
    assign zcalDone = zcalBusy_q && zcalCnt_q >= 32'(ZCAL_CYC - 1);

    // Mode sequencing and the shared mode timer.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            mode_q <= CMC_LAMP;
            timer_q <= '0;
        end
        else
        begin
            timer_q <= (deb_q[0] && !debPrev_q[0]) ? 32'h0 :
                timer_q + 32'h1;
            case (mode_q)
                CMC_LAMP:
                    if (timer_q >= 32'(LAMP_CYC - 1))
                    begin
                        mode_q <= CMC_NORMAL;
                        timer_q <= '0;
                    end
                CMC_NORMAL:
                    if (cellFault && !sweepOn_q)
                        mode_q <= CMC_ERROR;
                    else if (menuHeld)
                        mode_q <= CMC_DZERO;
                CMC_DZERO:
                    if (menuPress)
                        mode_q <= CMC_DSPAN;
                CMC_DSPAN:
                    if (menuPress)
                        mode_q <= CMC_GZERO;
                CMC_GZERO:
                    if (zcalDone)
                        mode_q <= CMC_GGAIN;
                    else if (menuPress && !zcalBusy_q)
                        mode_q <= CMC_GGAIN;
                CMC_GGAIN:
                    if (menuPress)
                        mode_q <= dual_q ? CMC_RZERO : CMC_NORMAL;
                CMC_RZERO:
                    if (zcalDone)
                        mode_q <= CMC_RGAIN;
                    else if (menuPress && !zcalBusy_q)
                        mode_q <= CMC_RGAIN;
                CMC_RGAIN:
                    if (menuPress)
                        mode_q <= CMC_NORMAL;
                CMC_ERROR:
                    if (menuPress)
                        mode_q <= CMC_NORMAL;
                default:
                    mode_q <= CMC_NORMAL;
            endcase
        end
    end

    // Blink phase and automatic zero timer.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            blinkCnt_q <= '0;
            blink_q <= 1'b0;
            zcalBusy_q <= 1'b0;
            zcalCnt_q <= '0;
        end
        else
        begin
            if (blinkCnt_q >= 32'(BLINK_CYC - 1))
            begin
                blinkCnt_q <= '0;
                blink_q <= ~blink_q;
            end
            else
                blinkCnt_q <= blinkCnt_q + 32'h1;
            if (zcalDone)
                zcalBusy_q <= 1'b0;
            else if ((mode_q == CMC_GZERO || mode_q == CMC_RZERO) &&
                (minusPress || plusPress) && !zcalBusy_q)
            begin
                zcalBusy_q <= 1'b1;
                zcalCnt_q <= '0;
            end
            else if (zcalBusy_q)
                zcalCnt_q <= zcalCnt_q + 32'h1;
        end
    end

    // Mode indication on the LEDs.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            greenLed <= 1'b1;
            redLed <= 1'b1;
        end
        else
        begin
            case (mode_q)
                CMC_LAMP:
                begin
                    greenLed <= 1'b1;
                    redLed <= 1'b1;
                end
                CMC_DZERO:
                begin
                    greenLed <= 1'b1;
                    redLed <= 1'b1;
                end
                CMC_DSPAN:
                begin
                    greenLed <= blink_q;
                    redLed <= blink_q;
                end
                CMC_GZERO:
                begin
                    greenLed <= 1'b1;
                    redLed <= 1'b0;
                end
                CMC_GGAIN:
                begin
                    greenLed <= blink_q;
                    redLed <= 1'b0;
                end
                CMC_RZERO:
                begin
                    greenLed <= 1'b0;
                    redLed <= 1'b1;
                end
                CMC_RGAIN:
                begin
                    greenLed <= 1'b0;
                    redLed <= blink_q;
                end
                CMC_ERROR:
                begin
                    greenLed <= blink_q;
                    redLed <= ~blink_q;
                end
                default:
                begin
                    greenLed <= 1'b0;
                    redLed <= 1'b0;
                end
            endcase
        end
    end

    // Calibration values change only on a step or a completed zero,
    // or on a reload from storage over the bus.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            dialOfs_q <= `CMC_RST_DOFS;
            dialSpan_q <= `CMC_RST_DSPAN;
            greenZero_q <= `CMC_RST_ZERO;
            greenGain_q <= `CMC_RST_GAIN;
            redZero_q <= `CMC_RST_ZERO;
            redGain_q <= `CMC_RST_GAIN;
        end
        else
        begin
            if (apbWr && paddr == `CMC_OFF_DOFS)
                dialOfs_q <= pwdata[15:0];
            else if (mode_q == CMC_DZERO && minusPress)
                dialOfs_q <= dialOfs_q - STEP;
            else if (mode_q == CMC_DZERO && plusPress)
                dialOfs_q <= dialOfs_q + STEP;
            if (apbWr && paddr == `CMC_OFF_DSPAN)
                dialSpan_q <= pwdata[15:0];
            else if (mode_q == CMC_DSPAN && minusPress)
                dialSpan_q <= dialSpan_q - STEP;
            else if (mode_q == CMC_DSPAN && plusPress)
                dialSpan_q <= dialSpan_q + STEP;
            if (apbWr && paddr == `CMC_OFF_GZERO)
                greenZero_q <= pwdata[15:0];
            else if (zcalDone && mode_q == CMC_GZERO)
                greenZero_q <= greenForce_q;
            if (apbWr && paddr == `CMC_OFF_RZERO)
                redZero_q <= pwdata[15:0];
            else if (zcalDone && mode_q == CMC_RZERO)
                redZero_q <= redForce_q;
            if (apbWr && paddr == `CMC_OFF_GGAIN)
                greenGain_q <= pwdata[15:0];
            else if (mode_q == CMC_GGAIN && minusPress)
                greenGain_q <= greenGain_q - STEP;
            else if (mode_q == CMC_GGAIN && plusPress)
                greenGain_q <= greenGain_q + STEP;
            if (apbWr && paddr == `CMC_OFF_RGAIN)
                redGain_q <= pwdata[15:0];
            else if (mode_q == CMC_RGAIN && minusPress)
                redGain_q <= redGain_q - STEP;
            else if (mode_q == CMC_RGAIN && plusPress)
                redGain_q <= redGain_q + STEP;
        end
    end

    // Net forces, gain per input, larger result wins in dual variant, then dial scaling.
    assign gNet = {1'b0, greenForce_q} - {1'b0, greenZero_q};
    assign rNet = {1'b0, redForce_q} - {1'b0, redZero_q};
    always_comb
    begin
        logic [31:0] gs;
        logic [31:0] rs;
        logic [15:0] best;
        gs = gNet[16] ? 32'h0 : 32'(gNet[15:0]) * 32'(greenGain_q);
        rs = rNet[16] ? 32'h0 : 32'(rNet[15:0]) * 32'(redGain_q);
        best = gs[29:14];
        if (dual_q && rs[29:14] > gs[29:14])
            best = rs[29:14];
        peakForce = best;
        scaled = 32'(peakForce) * 32'(dialSpan_q);
    end

    // Power-up sweep, fault full scale and periodic dial refresh.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sweep_q <= '0;
            sweepUp_q <= 1'b1;
            sweepOn_q <= 1'b1;
            refresh_q <= '0;
            dialValue <= '0;
        end
        else
        begin
            if (sweepOn_q && mode_q == CMC_NORMAL &&
                refresh_q >= 32'(REFRESH_CYC - 1))
            begin
                if (sweepUp_q)
                begin
                    if (sweep_q >= `CMC_SWEEP_TOP - STEP)
                        sweepUp_q <= 1'b0;
                    sweep_q <= sweep_q + STEP;
                end
                else if (sweep_q <= STEP)
                begin
                    sweep_q <= '0;
                    sweepOn_q <= 1'b0;
                end
                else
                    sweep_q <= sweep_q - STEP;
            end
            if (refresh_q >= 32'(REFRESH_CYC - 1))
            begin
                refresh_q <= '0;
                if (mode_q == CMC_ERROR)
                    dialValue <= `CMC_FULL;
                else if (sweepOn_q && mode_q == CMC_NORMAL)
                    dialValue <= sweep_q;
                else
                    dialValue <= scaled[30:15] + dialOfs_q;
            end
            else
                refresh_q <= refresh_q + 32'h1;
        end
    end

    // APB slave: zero wait states, unmapped addresses read zero with error.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            dual_q <= 1'b1;
            greenForce_q <= '0;
            redForce_q <= '0;
            saveReq <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            saveReq <= 1'b0;
            if (zcalDone || ((mode_q == CMC_GGAIN || mode_q == CMC_RGAIN)
                && menuPress))
                saveReq <= 1'b1;
            pready <= psel & ~pready;
            pslverr <= 1'b0;
            if (psel && !pready)
            begin
                prdata <= '0;
                case (paddr)
                    `CMC_OFF_CTRL: prdata <= {31'h0, dual_q};
                    `CMC_OFF_STATUS: prdata <= {20'h0, cellFault,
                        zcalBusy_q, 1'b0, mode_q};
                    `CMC_OFF_DOFS: prdata <= {16'h0, dialOfs_q};
                    `CMC_OFF_DSPAN: prdata <= {16'h0, dialSpan_q};
                    `CMC_OFF_GZERO: prdata <= {16'h0, greenZero_q};
                    `CMC_OFF_GGAIN: prdata <= {16'h0, greenGain_q};
                    `CMC_OFF_RZERO: prdata <= {16'h0, redZero_q};
                    `CMC_OFF_RGAIN: prdata <= {16'h0, redGain_q};
                    `CMC_OFF_GFORCE: prdata <= {16'h0, greenForce_q};
                    `CMC_OFF_RFORCE: prdata <= {16'h0, redForce_q};
                    `CMC_OFF_DIAL: prdata <= {16'h0, dialValue};
                    default: pslverr <= 1'b1;
                endcase
            end
            if (apbWr)
            begin
                case (paddr)
                    `CMC_OFF_CTRL: dual_q <= pwdata[`CMC_CTRL_DUAL];
                    `CMC_OFF_GFORCE: greenForce_q <= pwdata[15:0];
                    `CMC_OFF_RFORCE: redForce_q <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end
endmodule

// file: cmc_menu_assertions.sv
`timescale 1ns/10ps
`include "cmc_params.svh"
module cmc_menu_assertions #(
    parameter int REFRESH_CYC = 4
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Panel outputs.
    input wire logic greenLed,
    input wire logic redLed,
    input wire logic [15:0] dialValue,
    input wire logic saveReq
);
    logic [15:0] lastDial_q;
    int sinceChg_q;
    wire logic setupEdge = psel && !penable && !pready;
    wire logic mapped = {24'h0, paddr} <= `CMC_OFF_DIAL;

    // Counts cycles since the dial value last moved.
    always_ff @(posedge ref_clk)
    begin
        lastDial_q <= dialValue;
        if (srst)
            sinceChg_q <= REFRESH_CYC;
        else if (dialValue != lastDial_q)
            sinceChg_q <= 1;
        else if (sinceChg_q < REFRESH_CYC)
            sinceChg_q <= sinceChg_q + 1;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    a_ready_answer: assert property (setupEdge |=> pready)
        else $error("no answer after setup cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_unmapped_err: assert property (
        setupEdge && !mapped |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        setupEdge && mapped && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access refused");
    a_refresh_gap: assert property (
        dialValue != lastDial_q |-> sinceChg_q >= REFRESH_CYC)
        else $error("dial changed between refreshes");
    a_lamp_on: assert property (
        $fell(srst) |-> (greenLed && redLed) [*6])
        else $error("lamp test missing");
    a_lamp_off: assert property (
        $fell(srst) |-> ##[6:30] (!greenLed && !redLed))
        else $error("lamp test did not end");
    a_dial_home: assert property ($fell(srst) |-> dialValue == 16'h0)
        else $error("dial not at zero after reset");
    a_save_pulse: assert property (saveReq |=> !saveReq)
        else $error("save request longer than one cycle");
endmodule
bind cmc_calibration_menu cmc_menu_assertions #(
    .REFRESH_CYC(REFRESH_CYC)
) u_cmc_menu_assertions (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .greenLed(greenLed), .redLed(redLed), .dialValue(dialValue),
    .saveReq(saveReq)
);

// file: cmc_operator_model.sv
`timescale 1ns/10ps
module cmc_operator_model #(
    parameter int HOLD_CYC = 50
) (
    // Clock.
    input wire logic ref_clk,
    // Button pins, low while pressed.
    output logic menuBtn_n,
    output logic minusBtn_n,
    output logic plusBtn_n
);
    logic [2:0] pins_n = 3'b111;

    assign {plusBtn_n, minusBtn_n, menuBtn_n} = pins_n;

    // A press starts with a one-cycle bounce that must not count.
    task automatic press(input int which, input int holdCyc);
        @(posedge ref_clk);
        pins_n[which] <= 1'b0;
        @(posedge ref_clk);
        pins_n[which] <= 1'b1;
        @(posedge ref_clk);
        pins_n[which] <= 1'b0;
        repeat (holdCyc) @(posedge ref_clk);
        pins_n <= 3'b111;
        repeat (20) @(posedge ref_clk);
    endtask

    task automatic holdMenu();
        press(0, HOLD_CYC + 10);
    endtask
endmodule

// file: test_calibration_menu_controller.sv
`timescale 1ns/10ps
`include "cmc_params.svh"
module test_calibration_menu_controller;
    import cmc_pkg::*;
    localparam int HOLD = 50;
    localparam int ZCAL = 40;
    localparam logic [15:0] STEP = 16'h2000;
    localparam logic [31:0] ALL = 32'hffffffff;
    typedef struct {
        logic [31:0] data;
        logic [31:0] mask;
        logic err;
    } cmc_note_t;
    cmc_note_t notes[$];
    cmc_note_t seen;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic greenCellPresent = 1'b1;
    logic redCellPresent = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, greenLed, redLed, saveReq;
    logic menuBtn_n, minusBtn_n, plusBtn_n;
    logic [15:0] dialValue;
    logic [15:0] peak;
    logic [15:0] forceVal;
    int errors = 0;
    int check_count = 0;
    int saves = 0;

    always #5 ref_clk = ~ref_clk;

    cmc_calibration_menu #(
        .HOLD_CYC(HOLD), .ZCAL_CYC(ZCAL), .REFRESH_CYC(4), .BLINK_CYC(4),
        .LAMP_CYC(8), .DEB_CYC(2), .STEP(STEP)
    ) u_cmc_calibration_menu (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .menuBtn_n(menuBtn_n),
        .minusBtn_n(minusBtn_n), .plusBtn_n(plusBtn_n),
        .greenCellPresent(greenCellPresent), .redCellPresent(redCellPresent),
        .greenLed(greenLed), .redLed(redLed), .dialValue(dialValue),
        .saveReq(saveReq)
    );

    cmc_operator_model #(.HOLD_CYC(HOLD)) u_cmc_operator_model (
        .ref_clk(ref_clk), .menuBtn_n(menuBtn_n), .minusBtn_n(minusBtn_n),
        .plusBtn_n(plusBtn_n)
    );

    task automatic conclude();
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic compareWord(input logic [31:0] got, input logic [31:0] exp,
                               input logic gotErr, input logic expErr);
        check_count++;
        if (got !== exp || gotErr !== expErr)
        begin
            errors++;
            $display("mismatch at %0t: got %h/%b want %h/%b", $time, got,
                     gotErr, exp, expErr);
        end
    endtask

    task automatic compareFlag(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    // Takes the oldest note whenever an access completes.
    always @(posedge ref_clk)
    begin
        saves += (saveReq === 1'b1) ? 1 : 0;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            if (notes.size() == 0)
                compareFlag(1'b1, 1'b0);
            else
            begin
                seen = notes.pop_front();
                compareWord(prdata & seen.mask, seen.data & seen.mask,
                            pslverr, seen.err);
            end
        end
    end

    task automatic apb(input logic wr, input logic [31:0] addr,
                       input logic [31:0] wdata, input logic [31:0] exp,
                       input logic [31:0] mask);
        int n;
        n = 0;
        notes.push_back('{exp, mask, addr > `CMC_OFF_DIAL});
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr[7:0];
        pwdata <= wdata;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            conclude();
        end
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data, 32'h0, 32'h0);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0, exp, addr == `CMC_OFF_STATUS ? 32'h1ff : ALL);
    endtask

    task automatic press(input int which);
        u_cmc_operator_model.press(which, 6);
    endtask

    task automatic menu(input cmc_mode_t mode);
        press(0);
        rd(`CMC_OFF_STATUS, {23'h0, mode});
    endtask

    task automatic leds(input logic g, input logic r);
        @(negedge ref_clk);
        compareFlag(greenLed, g);
        compareFlag(redLed, r);
    endtask

    // Relation 0 together, 1 alternate, 2 red off, 3 green off.
    task automatic watch(input int rel);
        int toggles;
        logic last;
        logic blink;
        toggles = 0;
        last = (rel == 3) ? redLed : greenLed;
        repeat (16)
        begin
            @(negedge ref_clk);
            case (rel)
                0: compareFlag(redLed, greenLed);
                1: compareFlag(redLed, ~greenLed);
                2: compareFlag(redLed, 1'b0);
                default: compareFlag(greenLed, 1'b0);
            endcase
            blink = (rel == 3) ? redLed : greenLed;
            toggles += (blink !== last) ? 1 : 0;
            last = blink;
        end
        compareFlag(toggles > 1, 1'b1);
    endtask

    initial
    begin
        cmc_mode_t single[4];
        single = '{CMC_DSPAN, CMC_GZERO, CMC_GGAIN, CMC_NORMAL};
        void'($urandom(32'h7c0c31e1));
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        peak = 16'h0;
        repeat (120)
        begin
            @(negedge ref_clk);
            if (dialValue > peak)
                peak = dialValue;
        end
        compareWord({16'h0, peak}, {16'h0, `CMC_SWEEP_TOP}, 1'b0, 1'b0);
        compareWord({16'h0, dialValue}, 32'h0, 1'b0, 1'b0);
        leds(1'b0, 1'b0);
        rd(`CMC_OFF_CTRL, 32'h1 & ALL);
        rd(`CMC_OFF_STATUS, {23'h0, CMC_NORMAL});
        rd(`CMC_OFF_DSPAN, {16'h0, `CMC_RST_DSPAN});
        forceVal = 16'($urandom());
        wr(`CMC_OFF_RZERO, {16'h0, forceVal});
        rd(`CMC_OFF_RZERO, {16'h0, forceVal});
        wr(32'h40, 32'h5a5a5a5a);
        rd(32'h40, 32'h0);
        u_cmc_operator_model.holdMenu();
        rd(`CMC_OFF_STATUS, {23'h0, CMC_DZERO});
        leds(1'b1, 1'b1);
        press(2);
        press(2);
        press(1);
        rd(`CMC_OFF_DOFS, {16'h0, STEP});
        menu(CMC_DSPAN);
        watch(0);
        press(1);
        rd(`CMC_OFF_DSPAN, {16'h0, `CMC_RST_DSPAN - STEP});
        menu(CMC_GZERO);
        leds(1'b1, 1'b0);
        forceVal = 16'($urandom());
        wr(`CMC_OFF_GFORCE, {16'h0, forceVal});
        press(2);
        repeat (ZCAL + 20) @(posedge ref_clk);
        rd(`CMC_OFF_STATUS, {23'h0, CMC_GGAIN});
        rd(`CMC_OFF_GZERO, {16'h0, forceVal});
        compareFlag(saves == 1, 1'b1);
        watch(2);
        menu(CMC_RZERO);
        leds(1'b0, 1'b1);
        rd(`CMC_OFF_GGAIN, {16'h0, `CMC_RST_GAIN});
        menu(CMC_RGAIN);
        watch(3);
        press(2);
        rd(`CMC_OFF_RGAIN, {16'h0, `CMC_RST_GAIN + STEP});
        menu(CMC_NORMAL);
        leds(1'b0, 1'b0);
        repeat (60) @(posedge ref_clk);
        redCellPresent <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rd(`CMC_OFF_STATUS, {23'h0, CMC_ERROR});
        watch(1);
        rd(`CMC_OFF_DIAL, {16'h0, `CMC_FULL});
        menu(CMC_ERROR);
        redCellPresent <= 1'b1;
        menu(CMC_NORMAL);
        wr(`CMC_OFF_CTRL, 32'h0);
        u_cmc_operator_model.holdMenu();
        rd(`CMC_OFF_STATUS, {23'h0, CMC_DZERO});
        foreach (single[i])
            menu(single[i]);
        compareFlag(saves == 4, 1'b1);
        conclude();
    end
endmodule
